// [rtl/mcct_map.vh]
// Register offsets, field positions and reset values of the match/capture counter timer
`ifndef MCCT_MAP_VH
`define MCCT_MAP_VH
`define MCCT_OFF_CTRL    8'h00
`define MCCT_OFF_COUNT   8'h04
`define MCCT_OFF_PRESC   8'h08
`define MCCT_OFF_PCNT    8'h0C
`define MCCT_OFF_MCTRL   8'h10
`define MCCT_OFF_MATCH0  8'h14
`define MCCT_OFF_MATCH1  8'h18
`define MCCT_OFF_MATCH2  8'h1C
`define MCCT_OFF_MATCH3  8'h20
`define MCCT_OFF_CCTRL   8'h24
`define MCCT_OFF_CAP0    8'h28
`define MCCT_OFF_CAP1    8'h2C
`define MCCT_OFF_EVENT   8'h30
`define MCCT_OFF_OUTCFG  8'h34
`define MCCT_CTRL_EN     0
`define MCCT_CTRL_RST    1
`define MCCT_CTRL_CNTM   2
`define MCCT_CTRL_CSEL   3
`define MCCT_CTRL_CEDGE  4
`define MCCT_CTRL_CLRCAP 5
`define MCCT_CTRL_CLRCH  6
`define MCCT_CTRL_CLREDG 7
`define MCCT_CTRL_RESET  32'h0000_0000
`define MCCT_RESP_OKAY   2'b00
`define MCCT_RESP_SLVERR 2'b10
`endif

// [rtl/mcct_sync.v]
// Three-stage input synchroniser with agreement-based change detection
module mcct_sync (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  input  wire ce,
  // Asynchronous pin and its settled level
  input  wire din,
  output reg  level_r,
  output wire rise,
  output wire fall
);
  reg s1_r; // First stage, read only by s2_r
  reg s2_r; // Second stage
  reg s3_r; // Third stage

  // Shift pin through three stages; level moves once stages two and three agree
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end else if (ce) begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end

  // Edges of the settled level, one-cycle pulses
  assign rise = ce & (s2_r == s3_r) & s3_r & ~level_r;
  assign fall = ce & (s2_r == s3_r) & ~s3_r & level_r;
endmodule // mcct_sync

// [rtl/mcct_core.v]
// Counting core: prescaler and counter with enable, load and clear inputs
module mcct_core #(
  parameter W = 32
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst,
  input  wire         ce,
  // Controls
  input  wire         run,
  input  wire         sw_clr,
  input  wire         evt_clr,
  input  wire         tick_src,
  input  wire [W-1:0] presc,
  input  wire         cnt_set,
  input  wire [W-1:0] cnt_val,
  // State
  output reg  [W-1:0] pcnt_r,
  output reg  [W-1:0] count_r
);
  wire wrap = (pcnt_r >= presc); // Prescaler completes its programmed count

  // Prescaler then counter; clears win over counting
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pcnt_r  <= {W{1'b0}};
      count_r <= {W{1'b0}};
    end else if (ce) begin
      if (sw_clr || evt_clr) begin
        pcnt_r  <= {W{1'b0}};
        count_r <= {W{1'b0}};
      end else if (cnt_set) begin
        count_r <= cnt_val;
        pcnt_r  <= {W{1'b0}};
      end else if (run && tick_src) begin
        if (wrap) begin
          pcnt_r  <= {W{1'b0}};
          count_r <= count_r + {{(W-1){1'b0}}, 1'b1};
        end else begin
          pcnt_r <= pcnt_r + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // mcct_core

// [rtl/mcct_timer.v]
// Match/capture counter timer with AXI4-Lite register slave
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`include "mcct_map.vh"
module mcct_timer #(
  parameter W = 32
) (
  // Clock, enable and reset
  input  wire          clk,
  input  wire          rst,
  input  wire          ce,
  // AXI4-Lite write address and data
  input  wire [7:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  // Pins
  input  wire [1:0]    cap_in,
  output reg  [3:0]    match_out,
  // Event flags and converter triggers
  output wire          irq_flag,
  output wire [3:0]    adc_trig
);
  localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

  // Width a register value to the counter width
  function [W-1:0] lowbits;
    input [31:0] v;
    begin
      lowbits = v[W-1:0];
    end
  endfunction

  // Byte-lane merge of a write into an old word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (st[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // Zero-extend a counter-width value to the bus
  function [31:0] ext;
    input [W-1:0] v;
    begin
      ext = 32'h0000_0000;
      ext[W-1:0] = v;
    end
  endfunction

  // Count equals a match value and was not already compared at this value
  function hit_now;
    input [W-1:0] c;
    input [W-1:0] m;
    input [W-1:0] p;
    input         seen;
    begin
      hit_now = (c == m) & ~(seen & (c == p));
    end
  endfunction

  // Software registers
  reg  [7:0]    ctrl_r;      // Enable, reset, mode and capture-clear config
  reg  [W-1:0]  presc_r;     // Prescale limit
  reg  [11:0]   mctrl_r;     // Per match: irq, clear, halt
  reg  [W-1:0]  match_r [0:3];
  reg  [5:0]    cctrl_r;     // Per capture: rise, fall, irq
  reg  [W-1:0]  cap_r [0:1]; // Captured counts
  reg  [5:0]    event_r;     // Sticky match[3:0] and capture[5:4] flags
  reg  [7:0]    outcfg_r;    // Two bits per match output
  // Bus state and match history
  reg           aw_full_r;
  reg  [7:0]    aw_addr_r;
  reg           w_full_r;
  reg  [31:0]   w_data_r;
  reg  [3:0]    w_strb_r;
  reg  [W-1:0]  match_prev_r; // Previous count, one compare per count value
  reg           match_seen_r;
  // Core outputs
  wire [W-1:0]  count;
  wire [W-1:0]  pcnt;
  // Synchronised pins
  wire [1:0]    cap_lvl;
  wire [1:0]    cap_rise;
  wire [1:0]    cap_fall;

  // Capture pins cross from outside through three flip-flops
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sync
      mcct_sync u_sync (
        .clk     (clk),
        .rst     (rst),
        .ce      (ce),
        .din     (cap_in[g]),
        .level_r (cap_lvl[g]),
        .rise    (cap_rise[g]),
        .fall    (cap_fall[g])
      );
    end
  endgenerate

  // Capture events per channel on the selected transitions
  wire [1:0] cap_evt;
  assign cap_evt[0] = (cctrl_r[0] & cap_rise[0]) | (cctrl_r[1] & cap_fall[0]);
  assign cap_evt[1] = (cctrl_r[3] & cap_rise[1]) | (cctrl_r[4] & cap_fall[1]);

  // Counter mode counts the chosen edge of the chosen capture pin
  wire sel_pin   = ctrl_r[`MCCT_CTRL_CSEL];
  wire cnt_edge  = ctrl_r[`MCCT_CTRL_CEDGE] ? cap_fall[sel_pin] : cap_rise[sel_pin];
  wire tick_src  = ctrl_r[`MCCT_CTRL_CNTM] ? cnt_edge : 1'b1;

  // Capture-driven clear of counter and prescaler
  wire clr_ch    = ctrl_r[`MCCT_CTRL_CLRCH];
  wire clr_evt   = ctrl_r[`MCCT_CTRL_CLRCAP] &
                   (ctrl_r[`MCCT_CTRL_CLREDG] ? cap_fall[clr_ch] : cap_rise[clr_ch]);

  // Match detection once per new count value; one previous count serves all four
  wire [3:0] hit;
  assign hit[0] = hit_now(count, match_r[0], match_prev_r, match_seen_r);
  assign hit[1] = hit_now(count, match_r[1], match_prev_r, match_seen_r);
  assign hit[2] = hit_now(count, match_r[2], match_prev_r, match_seen_r);
  assign hit[3] = hit_now(count, match_r[3], match_prev_r, match_seen_r);
  // Hits count only while the timer runs and the clock is enabled
  wire [3:0] hit_ce = hit & {4{ce & ctrl_r[`MCCT_CTRL_EN]}};
  // Clear and halt requests of the matches that fired
  wire mclr  = |(hit_ce & {mctrl_r[10], mctrl_r[7], mctrl_r[4], mctrl_r[1]});
  wire mhalt = |(hit_ce & {mctrl_r[11], mctrl_r[8], mctrl_r[5], mctrl_r[2]});

  // Bus write decode
  wire        wr_go   = aw_full_r & w_full_r & ~s_axi_bvalid;
  wire        cnt_set = wr_go & (aw_addr_r == `MCCT_OFF_COUNT);
  wire [31:0] cnt_wv  = merge(ext(count), w_data_r, w_strb_r);
  // Limitation: a count write loses to a clear arriving in the same cycle

  // Merged write words, cut on purpose to the width of each narrow register
  wire [31:0] ctrl_wv  = merge({{24{1'b0}}, ctrl_r}, w_data_r, w_strb_r);
  wire [31:0] mctrl_wv = merge({{20{1'b0}}, mctrl_r}, w_data_r, w_strb_r);
  wire [31:0] cctrl_wv = merge({{26{1'b0}}, cctrl_r}, w_data_r, w_strb_r);

  // Counting core
  mcct_core #(
    .W (W)
  ) u_core (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .run      (ctrl_r[`MCCT_CTRL_EN]),
    .sw_clr   (ctrl_r[`MCCT_CTRL_RST]),
    .evt_clr  (clr_evt | mclr),
    .tick_src (tick_src),
    .presc    (presc_r),
    .cnt_set  (cnt_set),
    .cnt_val  (lowbits(cnt_wv)),
    .pcnt_r   (pcnt),
    .count_r  (count)
  );

  // Remember last compared count so a held count matches only once
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      match_prev_r <= {W{1'b0}};
      match_seen_r <= 1'b0;
    end else if (ce) begin
      match_prev_r <= count;
      match_seen_r <= ctrl_r[`MCCT_CTRL_EN];
    end
  end

  // Channel handshakes: accept each write half independently, one read at a time
  assign s_axi_awready = ~aw_full_r;
  assign s_axi_wready  = ~w_full_r;
  assign s_axi_arready = ~s_axi_rvalid;

  // Mapped write offsets
  wire wr_ok = (aw_addr_r[1:0] == 2'b00) && (aw_addr_r <= `MCCT_OFF_OUTCFG);

  // Write path, control registers, flags and match outputs
  integer k;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_full_r    <= 1'b0;
      aw_addr_r    <= 8'h00;
      w_full_r     <= 1'b0;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MCCT_RESP_OKAY;
      ctrl_r       <= 8'h00;
      presc_r      <= {W{1'b0}};
      mctrl_r      <= 12'h000;
      cctrl_r      <= 6'h00;
      outcfg_r     <= 8'h00;
      event_r      <= 6'h00;
      match_out    <= 4'h0;
      cap_r[0]     <= {W{1'b0}};
      cap_r[1]     <= {W{1'b0}};
      for (k = 0; k < 4; k = k + 1) begin
        match_r[k] <= {W{1'b0}};
      end
    end else if (ce) begin
      // Latch address and data halves
      if (s_axi_awvalid && !aw_full_r) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_r) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Halt on match stops the enable bit
      if (mhalt) begin
        ctrl_r[`MCCT_CTRL_EN] <= 1'b0;
      end
      // Register write; halt applied first so a write can restart
      if (wr_go) begin
        aw_full_r    <= 1'b0;
        w_full_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `MCCT_RESP_OKAY : `MCCT_RESP_SLVERR;
        case (aw_addr_r)
          `MCCT_OFF_CTRL: begin
            ctrl_r <= ctrl_wv[7:0];
          end
          `MCCT_OFF_PRESC:  presc_r  <= lowbits(merge(ext(presc_r), w_data_r, w_strb_r));
          `MCCT_OFF_MCTRL:  mctrl_r  <= mctrl_wv[11:0];
          `MCCT_OFF_MATCH0: match_r[0] <= lowbits(merge(ext(match_r[0]), w_data_r, w_strb_r));
          `MCCT_OFF_MATCH1: match_r[1] <= lowbits(merge(ext(match_r[1]), w_data_r, w_strb_r));
          `MCCT_OFF_MATCH2: match_r[2] <= lowbits(merge(ext(match_r[2]), w_data_r, w_strb_r));
          `MCCT_OFF_MATCH3: match_r[3] <= lowbits(merge(ext(match_r[3]), w_data_r, w_strb_r));
          `MCCT_OFF_CCTRL:  cctrl_r  <= cctrl_wv[5:0];
          `MCCT_OFF_OUTCFG: outcfg_r <= w_strb_r[0] ? w_data_r[7:0] : outcfg_r;
          default: begin
            // Count, event, read-only or unmapped: no store here
          end
        endcase
      end
      // Event flags: write-one-to-clear, a new event wins over the clear
      event_r <= (event_r & ~((wr_go && aw_addr_r == `MCCT_OFF_EVENT && w_strb_r[0]) ?
                 w_data_r[5:0] : 6'h00))
                 | {cap_evt[1] & cctrl_r[5], cap_evt[0] & cctrl_r[2],
                    hit_ce[3] & mctrl_r[9], hit_ce[2] & mctrl_r[6],
                    hit_ce[1] & mctrl_r[3], hit_ce[0] & mctrl_r[0]};
      // Capture latches
      for (k = 0; k < 2; k = k + 1) begin
        if (cap_evt[k]) begin
          cap_r[k] <= count;
        end
      end
      // Match output actions
      for (k = 0; k < 4; k = k + 1) begin
        if (hit_ce[k]) begin
          case (outcfg_r[k*2 +: 2])
            2'b01:   match_out[k] <= 1'b0;
            2'b10:   match_out[k] <= 1'b1;
            2'b11:   match_out[k] <= ~match_out[k];
            default: match_out[k] <= match_out[k];
          endcase
        end
      end
    end
  end

  // Read path: registered data, answered one cycle after address
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `MCCT_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `MCCT_RESP_OKAY;
        case (s_axi_araddr)
          `MCCT_OFF_CTRL:   s_axi_rdata <= {24'h0, ctrl_r};
          `MCCT_OFF_COUNT:  s_axi_rdata <= ext(count);
          `MCCT_OFF_PRESC:  s_axi_rdata <= ext(presc_r);
          `MCCT_OFF_PCNT:   s_axi_rdata <= ext(pcnt);
          `MCCT_OFF_MCTRL:  s_axi_rdata <= {20'h0, mctrl_r};
          `MCCT_OFF_MATCH0: s_axi_rdata <= ext(match_r[0]);
          `MCCT_OFF_MATCH1: s_axi_rdata <= ext(match_r[1]);
          `MCCT_OFF_MATCH2: s_axi_rdata <= ext(match_r[2]);
          `MCCT_OFF_MATCH3: s_axi_rdata <= ext(match_r[3]);
          `MCCT_OFF_CCTRL:  s_axi_rdata <= {26'h0, cctrl_r};
          `MCCT_OFF_CAP0:   s_axi_rdata <= ext(cap_r[0]);
          `MCCT_OFF_CAP1:   s_axi_rdata <= ext(cap_r[1]);
          `MCCT_OFF_EVENT:  s_axi_rdata <= {26'h0, event_r};
          `MCCT_OFF_OUTCFG: s_axi_rdata <= {24'h0, outcfg_r};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MCCT_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Any sticky event raises the flag; 16-bit instances feed converter triggers
  assign irq_flag = |event_r;
  assign adc_trig = (W == 16) ? match_out : 4'h0;
  // Settled pin levels are not needed here; only their edges are used
  wire unused_ok = &{1'b0, cap_lvl, ONE[0]};
endmodule // mcct_timer

// [testbench/mcct_timer_monitor.sv]
// Bus handshake and pin checks for the counter timer
module mcct_timer_monitor #(
  parameter W = 32
) (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Bus handshakes
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Pins and flags
  input wire [3:0]  match_out,
  input wire        irq_flag,
  input wire [3:0]  adc_trig
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Answers stand until taken
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer moved");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer moved");
  // One address held at a time; reads answered next cycle, writes one cycle later
  aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second address taken while one is held");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  rd_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("write not answered");
  // Refused reads carry no data
  rd_err_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0000_0000)
    else $error("refused read has data");
  // 16-bit instances feed the converter
  trig_route_a: assert property (adc_trig == ((W == 16) ? match_out : 4'h0))
    else $error("trigger routing wrong");
  // Reset keeps outputs quiet; checked while reset is high
  rst_quiet_a: assert property (disable iff (1'b0) rst |-> match_out == 4'h0 && !irq_flag
    && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs active in reset");
endmodule // mcct_timer_monitor

bind mcct_timer mcct_timer_monitor #(.W(W)) u_mcct_timer_monitor (
  .clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .match_out(match_out),
  .irq_flag(irq_flag), .adc_trig(adc_trig));

// [testbench/mcct_pin_model.sv]
// Model of the external capture pin source
module mcct_pin_model (
  input  wire        clk,
  input  wire        start,
  input  wire [7:0]  hi_len,
  input  wire [3:0]  n_pulse,
  output logic [1:0] cap_in,
  output logic       busy
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pulse train, equal high and low spans; both pins follow
  initial begin
    cap_in = 2'b00;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (start) begin
        busy <= 1'b1;
        repeat (n_pulse) begin
          cap_in <= 2'b11;
          repeat (hi_len) @(posedge clk);
          cap_in <= 2'b00;
          repeat (hi_len) @(posedge clk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule // mcct_pin_model

// [testbench/test_match_capture_counter_timer.sv]
// Self-checking bench for the match/capture counter timer
`include "mcct_map.vh"
module test_match_capture_counter_timer;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] d, rd;
    logic [1:0]  r;
  } mcct_row_t;                       // Address, write, readback, response
  localparam int P = 7;               // Prescale for the match mode tests
  localparam int M = 4;               // Halt match value
  logic        clk = 1'b0;
  logic        rst = 1'b0;
  logic        ce = 1'b1;             // Clock enable, lowered in the freeze test
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire         awready, wready, bvalid, arready, rvalid, irq_flag, busy;
  wire  [1:0]  bresp, rresp, cap_in;
  wire  [31:0] rdata;
  wire  [3:0]  match_out, adc_trig;
  logic        start = 0;
  logic [7:0]  hi_len = 8'h01;
  logic [3:0]  n_pulse = 4'h1;
  int          miscompares = 0, num_checks = 0, t;
  logic [31:0] v;
  logic [1:0]  r;
  mcct_row_t   rows [6];
  logic [1:0]  modes [4] = '{2'b10, 2'b01, 2'b00, 2'b11};
  logic [3:0]  mexp = 4'b1001;        // Pin level after each mode

  always #20 clk = ~clk;

  mcct_timer #(.W(16)) u_mcct_timer (.clk(clk), .rst(rst), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cap_in(cap_in), .match_out(match_out), .irq_flag(irq_flag), .adc_trig(adc_trig));
  mcct_pin_model u_mcct_pin_model (.clk(clk), .start(start), .hi_len(hi_len),
    .n_pulse(n_pulse), .cap_in(cap_in), .busy(busy));

  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // Pin train, returns when the model is idle again
  task automatic pulse(input logic [7:0] h, input logic [3:0] k);
    hi_len <= h;
    n_pulse <= k;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    t = 0;
    while (busy && t < 3000) begin
      @(posedge clk);
      t++;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Hang guard, far above the fewer than a thousand cycles used
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end

  initial begin
    // Large match values keep stray events out of later tests
    rows = '{'{`MCCT_OFF_PRESC, 32'hFFFF_FFFF, 32'h0000_FFFF, `MCCT_RESP_OKAY},
             '{`MCCT_OFF_MATCH1, 32'h1234_5678, 32'h0000_5678, `MCCT_RESP_OKAY},
             '{`MCCT_OFF_MATCH2, 32'h0000_8000, 32'h0000_8000, `MCCT_RESP_OKAY},
             '{`MCCT_OFF_MATCH3, 32'hFFFF_FFF0, 32'h0000_FFF0, `MCCT_RESP_OKAY},
             '{8'h38, 32'h0000_0001, 32'h0000_0000, `MCCT_RESP_SLVERR},
             '{8'hFC, 32'h0000_0001, 32'h0000_0000, `MCCT_RESP_SLVERR}};
    rst <= 1'b1;                      // Real edge on reset before the first clock
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`MCCT_OFF_CTRL);
    chk("ctrl reset", v, `MCCT_CTRL_RESET);
    rd(`MCCT_OFF_EVENT);
    chk("event reset", v, 32'h0000_0000);
    chk("pins reset", match_out, 4'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk("bresp", r, rows[i].r);
      rd(rows[i].a);
      chk("rresp", r, rows[i].r);
      chk("rdata", v, rows[i].rd);
    end
    $display("test registers done");
    // Halt on match once per output mode
    wr(`MCCT_OFF_PRESC, P);
    wr(`MCCT_OFF_MATCH0, M);
    wr(`MCCT_OFF_MCTRL, 32'h0000_0005);
    for (int i = 0; i < 4; i++) begin
      wr(`MCCT_OFF_OUTCFG, 32'(modes[i]));
      wr(`MCCT_OFF_COUNT, 32'h0000_0000);
      wr(`MCCT_OFF_EVENT, 32'h0000_000F);
      chk("irq idle", irq_flag, 1'b0);
      wr(`MCCT_OFF_CTRL, 32'h0000_0001);
      t = 0;
      while (!irq_flag && t < 100) begin
        @(posedge clk);
        t++;
      end
      chk("match time", t >= M * (P + 1) - 3 && t <= M * (P + 1) + 3, 1'b1);
      rd(`MCCT_OFF_CTRL);
      chk("halted", v[0], 1'b0);
      rd(`MCCT_OFF_COUNT);
      chk("held count", v, M);
      chk("match pin", match_out[0], mexp[i]);
      chk("trigger", adc_trig, {3'b000, mexp[i]});
      rd(`MCCT_OFF_EVENT);
      chk("match event", v, 32'h0000_0001);
    end
    $display("test match modes done");
    // Clear on match with a toggling pin
    wr(`MCCT_OFF_MCTRL, 32'h0000_0002);
    wr(`MCCT_OFF_PRESC, 32'h0000_0000);
    wr(`MCCT_OFF_MATCH0, 32'h0000_0002);
    wr(`MCCT_OFF_OUTCFG, 32'h0000_0003);
    wr(`MCCT_OFF_COUNT, 32'h0000_0000);
    wr(`MCCT_OFF_CTRL, 32'h0000_0001);
    t = 0;
    v[0] = match_out[0];
    repeat (90) begin
      @(posedge clk);
      if (match_out[0] !== v[0]) t++;
      v[0] = match_out[0];
    end
    chk("toggles", t >= 20 && t <= 45, 1'b1);
    chk("trigger rest", adc_trig[3:1], 3'b000);
    wr(`MCCT_OFF_CTRL, 32'h0000_0000);
    wr(`MCCT_OFF_MCTRL, 32'h0000_0000);
    $display("test clear on match done");
    // Rising edge clears, falling edge captures the width
    wr(`MCCT_OFF_EVENT, 32'h0000_003F);
    wr(`MCCT_OFF_CCTRL, 32'h0000_0031);
    wr(`MCCT_OFF_COUNT, 32'h0000_0000);
    wr(`MCCT_OFF_CTRL, 32'h0000_0021);
    pulse(8'h32, 4'h1);
    rd(`MCCT_OFF_CAP1);
    chk("width", v >= 46 && v <= 52, 1'b1);
    rd(`MCCT_OFF_EVENT);
    chk("capture event", v[5], 1'b1);
    chk("capture irq", irq_flag, 1'b1);
    $display("test capture done");
    // Counter mode counts falling edges of the second pin
    wr(`MCCT_OFF_CTRL, 32'h0000_0000);
    wr(`MCCT_OFF_CCTRL, 32'h0000_0000);
    wr(`MCCT_OFF_COUNT, 32'h0000_0000);
    wr(`MCCT_OFF_CTRL, 32'h0000_001D);
    pulse(8'h06, 4'h5);
    repeat (8) @(posedge clk);
    rd(`MCCT_OFF_COUNT);
    chk("edge count", v, 32'h0000_0005);
    $display("test counter mode done");
    // Edges while the clock enable is low are lost, count stays
    ce <= 1'b0;
    pulse(8'h06, 4'h2);
    ce <= 1'b1;
    rd(`MCCT_OFF_COUNT);
    chk("frozen count", v, 32'h0000_0005);
    // Software reset holds counter and prescaler at zero
    wr(`MCCT_OFF_CTRL, 32'h0000_0003);
    rd(`MCCT_OFF_COUNT);
    chk("sw reset count", v, 32'h0000_0000);
    rd(`MCCT_OFF_PCNT);
    chk("sw reset pcnt", v, 32'h0000_0000);
    // Second reset in mid-run clears captures, control and flags
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`MCCT_OFF_CAP1);
    chk("cap after reset", v, 32'h0000_0000);
    rd(`MCCT_OFF_CTRL);
    chk("ctrl after reset", v, `MCCT_CTRL_RESET);
    chk("irq after reset", irq_flag, 1'b0);
    $display("test freeze and reset done");
    stop_test();
  end
endmodule // test_match_capture_counter_timer
